// file: hdl/smp_port.sv
// Overview of operation
// - Bytes shift most significant bit first.
// - Master starts; MOSI out, MISO back, one clock.
// - Polarity and phase pick four timing modes.
// - Software select replaces the select pin.
// - First-edge slave: write under select collides.
// - Master drives SCK at configured rate, mode.
// - Idle SCK rests at the polarity level.
// - Master and enable bits need select high.
// - Master data write loads and starts shifting.
// - Byte end sets done flag, may interrupt.
// - Done flag clears: status access, data read; slave data write too.
// - Done flag blocks data writes until status read.
// - Slave shifts on incoming SCK edges.
// - Select low in master mode: fault, disable.
// - Fault clears: status read, control write.
// - Fault blocks setting enable and master bits.
// - Byte during pending flag: overrun, keep first.
// - Status read clears overrun flag.
// - Write during transfer discarded, collision flagged.
// - One interrupt for done, fault, overrun.
// - Phase selects first or second capture edge.
// - Three bits pick master SCK division.
// - Reset clears port enable.
`timescale 1ns/1ps
module smp_port import smp_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cr_wr,
    input wire logic [7:0] cr_wdata,
    output logic [7:0] cr_rdata,
    input wire logic csr_rd,
    input wire logic csr_wr,
    input wire logic [7:0] csr_wdata,
    output logic [7:0] csr_rdata,
    input wire logic dr_rd,
    input wire logic dr_wr,
    input wire logic [7:0] dr_wdata,
    output logic [7:0] dr_rdata,
    output logic irq,
    input wire logic ss_n_in,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready
);
    logic [7:0] cr_reg;
    logic [7:0] cr_next;
    logic [7:0] csr_reg;
    logic [7:0] csr_next;
    logic [7:0] read_buf_reg;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [2:0] bit_cnt_reg;
    logic out_bit_reg;
    logic out_bit_next;
    logic cap_bit_reg;
    logic sck_reg;
    logic sck_prev_reg;
    logic sck_oe_n_reg;
    logic mosi_oe_n_reg;
    logic miso_oe_n_reg;
    logic irq_reg;
    logic tx_pending_reg;
    logic done_arm_reg;
    logic csr_read_seen_reg;
    logic fault_arm_reg;
    logic coll_arm_reg;
    smp_state_e state_reg;
    smp_state_e state_next;

    logic ss_int;
    logic clk_pol;
    logic clk_phase;
    logic master_on;
    logic slave_on;
    logic mode_fault;
    logic tick;
    logic m_lead;
    logic m_trail;
    logic s_lead;
    logic s_trail;
    logic lead;
    logic trail;
    logic in_bit;
    logic byte_done;
    logic [7:0] rx_byte;
    logic slave_busy;
    logic busy;
    logic wr_blocked;
    logic dr_accept;
    logic clear_done;
    logic done_held;
    logic set_overrun;
    logic set_collision;
    logic clear_collision;
    logic clear_fault;
    logic csr_access;
    logic start;
    logic buf_in_ready;
    logic div_run;
    logic [2:0] div_sel;
    logic pins_master;
    logic pins_slave;

    // Internal select from pin or software bit
    assign ss_int = csr_reg[CSR_SOFT_SEL] ? csr_reg[CSR_SOFT_LEVEL] : ss_n_in;
    assign clk_pol = cr_reg[CR_POLARITY];
    assign clk_phase = cr_reg[CR_PHASE];
    assign master_on = cr_reg[CR_ENABLE] & cr_reg[CR_MASTER];
    assign slave_on = cr_reg[CR_ENABLE] & !cr_reg[CR_MASTER];
    // Master sees select low: fault
    assign mode_fault = master_on & !ss_int;

    // Master clock edges from the divider ticks
    assign m_lead = tick & (sck_reg == clk_pol);
    assign m_trail = tick & (sck_reg != clk_pol);
    // Slave edges from the incoming clock while selected
    assign s_lead = slave_on & !ss_int & (sck_prev_reg == clk_pol) & (sck_in != clk_pol);
    assign s_trail = slave_on & !ss_int & (sck_prev_reg != clk_pol) & (sck_in == clk_pol);
    assign lead = (state_reg == ST_SHIFT) ? m_lead : s_lead;
    assign trail = (state_reg == ST_SHIFT) ? m_trail : s_trail;
    assign in_bit = cr_reg[CR_MASTER] ? miso_in : mosi_in;

    // Phase zero captures on the leading edge, phase one on the trailing
    assign rx_byte = {shift_reg[6:0], (clk_phase ? in_bit : cap_bit_reg)};
    assign byte_done = trail & (bit_cnt_reg == BIT_LAST);

    // Transfer activity for collision checks
    assign slave_busy = slave_on & !ss_int & (!clk_phase || (bit_cnt_reg != 3'h0));
    assign busy = (state_reg == ST_SHIFT) | tx_pending_reg | slave_busy;
    assign wr_blocked = csr_reg[CSR_DONE] & !csr_read_seen_reg;
    assign dr_accept = dr_wr & !busy & !wr_blocked & cr_reg[CR_ENABLE];
    assign set_collision = dr_wr & busy;
    assign clear_collision = coll_arm_reg & (dr_rd | dr_wr);

    // Done flag clear sequence; master needs a read
    assign clear_done = done_arm_reg & (dr_rd | (dr_wr & !cr_reg[CR_MASTER]));
    assign done_held = csr_reg[CSR_DONE] & !clear_done;
    assign set_overrun = byte_done & done_held;
    assign clear_fault = fault_arm_reg & cr_wr;
    assign csr_access = (csr_rd | csr_wr) & csr_reg[CSR_DONE];

    // Divider control and pin enable selects
    assign div_run = (state_reg == ST_SHIFT);
    assign div_sel = {cr_reg[CR_DIV2], cr_reg[CR_DIV1], cr_reg[CR_DIV0]};
    assign pins_master = cr_next[CR_ENABLE] & cr_next[CR_MASTER];
    assign pins_slave = cr_next[CR_ENABLE] & !cr_next[CR_MASTER] & !ss_int;

    // Master start waits for room in the receive stream buffer
    assign start = (state_reg == ST_IDLE) & tx_pending_reg & master_on & buf_in_ready;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (mode_fault || byte_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Control register with fault lockout
    always_comb begin
        cr_next = cr_reg;
        if (cr_wr) begin
            cr_next = cr_wdata;
            if (csr_reg[CSR_FAULT] && !clear_fault) begin
                cr_next[CR_ENABLE] = cr_reg[CR_ENABLE];
                cr_next[CR_MASTER] = cr_reg[CR_MASTER];
            end
        end
        if (mode_fault) begin
            cr_next[CR_ENABLE] = 1'b0;
            cr_next[CR_MASTER] = 1'b0;
        end
    end

    // Status flags; a setting event wins over a clear
    always_comb begin
        csr_next = csr_reg;
        if (csr_wr) begin
            csr_next[CSR_SOFT_SEL] = csr_wdata[CSR_SOFT_SEL];
            csr_next[CSR_SOFT_LEVEL] = csr_wdata[CSR_SOFT_LEVEL];
        end
        csr_next[CSR_DONE] = byte_done | done_held;
        csr_next[CSR_OVERRUN] = set_overrun | (csr_reg[CSR_OVERRUN] & !csr_rd);
        csr_next[CSR_COLLISION] = set_collision | (csr_reg[CSR_COLLISION] & !clear_collision);
        csr_next[CSR_FAULT] = mode_fault | (csr_reg[CSR_FAULT] & !clear_fault);
    end

    // Shift register, output bit and capture
    always_comb begin
        shift_next = shift_reg;
        out_bit_next = out_bit_reg;
        if (dr_accept) begin
            shift_next = dr_wdata;
            out_bit_next = dr_wdata[7];
        end else if (lead && clk_phase) begin
            out_bit_next = shift_reg[7];
        end else if (trail) begin
            shift_next = rx_byte;
            out_bit_next = clk_phase ? out_bit_reg : shift_reg[6];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cr_reg <= CR_RESET;
            csr_reg <= CSR_RESET;
            state_reg <= ST_IDLE;
        end else begin
            cr_reg <= cr_next;
            csr_reg <= csr_next;
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shift_reg <= DATA_RESET;
            out_bit_reg <= 1'b0;
            cap_bit_reg <= 1'b0;
            bit_cnt_reg <= 3'h0;
        end else begin
            shift_reg <= shift_next;
            out_bit_reg <= out_bit_next;
            if (lead) begin
                cap_bit_reg <= in_bit;
            end
            if ((slave_on && ss_int) || start || mode_fault) begin
                bit_cnt_reg <= 3'h0;
            end else if (trail) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
        end
    end

    // Read buffer keeps the first byte after a flag clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            read_buf_reg <= DATA_RESET;
        end else if (byte_done && !done_held) begin
            read_buf_reg <= rx_byte;
        end
    end

    // Clear-sequence tracking
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_arm_reg <= 1'b0;
            csr_read_seen_reg <= 1'b0;
            fault_arm_reg <= 1'b0;
            coll_arm_reg <= 1'b0;
        end else begin
            done_arm_reg <= csr_next[CSR_DONE] & (done_arm_reg | csr_access);
            csr_read_seen_reg <= csr_next[CSR_DONE] & (csr_read_seen_reg | csr_rd);
            fault_arm_reg <= csr_next[CSR_FAULT] & (fault_arm_reg | (csr_rd & csr_reg[CSR_FAULT]));
            coll_arm_reg <= csr_next[CSR_COLLISION] & (coll_arm_reg | (csr_rd & csr_reg[CSR_COLLISION]));
        end
    end

    // Master transmit request and serial clock
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_pending_reg <= 1'b0;
            sck_reg <= 1'b0;
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_in;
            if (mode_fault || start) begin
                tx_pending_reg <= 1'b0;
            end else if (dr_accept && cr_reg[CR_MASTER]) begin
                tx_pending_reg <= 1'b1;
            end
            if (state_reg != ST_SHIFT || mode_fault) begin
                sck_reg <= clk_pol;
            end else if (tick) begin
                sck_reg <= !sck_reg;
            end
        end
    end

    // Pin enables and interrupt, all registered
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sck_oe_n_reg <= 1'b1;
            mosi_oe_n_reg <= 1'b1;
            miso_oe_n_reg <= 1'b1;
            irq_reg <= 1'b0;
        end else begin
            sck_oe_n_reg <= !pins_master;
            mosi_oe_n_reg <= !pins_master;
            miso_oe_n_reg <= !pins_slave;
            irq_reg <= cr_next[CR_IRQ_EN] & (csr_next[CSR_DONE] | csr_next[CSR_FAULT] | csr_next[CSR_OVERRUN]);
        end
    end

    smp_rate_div u_rate_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(div_run),
        .rate_sel(div_sel),
        .tick(tick)
    );

    // Completed bytes also feed the receive stream; slave bytes are lost when it is full
    smp_rx_buf u_rx_buf (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(byte_done),
        .in_data(rx_byte),
        .in_ready(buf_in_ready),
        .out_valid(rx_valid),
        .out_data(rx_data),
        .out_ready(rx_ready)
    );

    assign cr_rdata = cr_reg;
    assign csr_rdata = csr_reg;
    assign dr_rdata = read_buf_reg;
    assign irq = irq_reg;
    assign sck_out = sck_reg;
    assign sck_oe_n = sck_oe_n_reg;
    assign mosi_out = out_bit_reg;
    assign mosi_oe_n = mosi_oe_n_reg;
    assign miso_out = out_bit_reg;
    assign miso_oe_n = miso_oe_n_reg;
endmodule

// file: hdl/smp_pkg.sv
package smp_pkg;

    // Control register field positions
    localparam int CR_DIV0 = 0;
    localparam int CR_DIV1 = 1;
    localparam int CR_PHASE = 2;
    localparam int CR_POLARITY = 3;
    localparam int CR_MASTER = 4;
    localparam int CR_DIV2 = 5;
    localparam int CR_ENABLE = 6;
    localparam int CR_IRQ_EN = 7;
    localparam logic [7:0] CR_RESET = 8'h00;

    // Control/status register field positions
    localparam int CSR_SOFT_LEVEL = 0;
    localparam int CSR_SOFT_SEL = 1;
    localparam int CSR_FAULT = 4;
    localparam int CSR_OVERRUN = 5;
    localparam int CSR_COLLISION = 6;
    localparam int CSR_DONE = 7;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Rate select codes {spr2, spr1, spr0}
    localparam logic [2:0] RATE_DIV4 = 3'h4;
    localparam logic [2:0] RATE_DIV8 = 3'h0;
    localparam logic [2:0] RATE_DIV16 = 3'h1;
    localparam logic [2:0] RATE_DIV32 = 3'h6;
    localparam logic [2:0] RATE_DIV64 = 3'h2;
    localparam logic [2:0] RATE_DIV128 = 3'h3;

    // SCK half periods in sys_clk cycles, minus one
    localparam logic [5:0] HALF_DIV4 = 6'h01;
    localparam logic [5:0] HALF_DIV8 = 6'h03;
    localparam logic [5:0] HALF_DIV16 = 6'h07;
    localparam logic [5:0] HALF_DIV32 = 6'h0F;
    localparam logic [5:0] HALF_DIV64 = 6'h1F;
    localparam logic [5:0] HALF_DIV128 = 6'h3F;

    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } smp_state_e;

endpackage

// file: hdl/smp_rate_div.sv
`timescale 1ns/1ps
module smp_rate_div import smp_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [2:0] rate_sel,
    output logic tick
);
    logic [5:0] cnt_reg;
    logic [5:0] half_last;
    logic at_last;

    // Rate decode
    assign half_last = (rate_sel == RATE_DIV4) ? HALF_DIV4 :
                       (rate_sel == RATE_DIV8) ? HALF_DIV8 :
                       (rate_sel == RATE_DIV16) ? HALF_DIV16 :
                       (rate_sel == RATE_DIV32) ? HALF_DIV32 :
                       (rate_sel == RATE_DIV64) ? HALF_DIV64 : HALF_DIV128;
    assign at_last = (cnt_reg >= half_last);
    assign tick = run & at_last;

    always_ff @(posedge sys_clk) begin
        if (rst || !run || at_last) begin
            cnt_reg <= 6'h00;
        end else begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end
endmodule

// file: hdl/smp_rx_buf.sv
`timescale 1ns/1ps
module smp_rx_buf (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic out_ready
);
    logic [7:0] mem_reg [0:1];
    logic [1:0] count_reg;
    logic rd_ptr_reg;
    logic wr_ptr_reg;
    logic push;
    logic pop;

    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem_reg[rd_ptr_reg];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_reg <= 2'h0;
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
        end else begin
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            wr_ptr_reg <= wr_ptr_reg ^ push;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end
endmodule

// file: sim/smp_slave_model.sv
`timescale 1ns/1ps
module smp_slave_model (
    input wire logic sys_clk,
    input wire logic sel_n,
    input wire logic clk_pol,
    input wire logic clk_phase,
    input wire logic sck,
    input wire logic mosi,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic sck_d = 1'b0;
    logic sel_d = 1'b1;
    int n = 0;
    initial miso = 1'b0;
    initial rx_byte = 8'h00;
    always @(posedge sys_clk) begin
        sck_d <= sck;
        sel_d <= sel_n;
        if (sel_n) begin
            n <= 0;
            miso <= ~miso; // Released line shows no stale bit
        end else if (sel_d) begin
            miso <= clk_phase ? ~miso : tx_byte[7];
        end else if (sck != sck_d) begin
            if ((sck != clk_pol) ^ clk_phase) begin
                rx_byte <= {rx_byte[6:0], mosi};
                n <= n + 1;
            end else if (n < 8) begin
                miso <= tx_byte[3'(7 - n)];
            end
        end
    end
endmodule

// file: sim/smp_port_props.sv
`timescale 1ns/1ps
module smp_port_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] cr_rdata,
    input wire logic csr_rd,
    input wire logic [7:0] csr_rdata,
    input wire logic irq,
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic mosi_oe_n,
    input wire logic miso_oe_n,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_ready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic flags = csr_rdata[7] | csr_rdata[5] | csr_rdata[4];
    a_idle_sck_level: assert property ($rose(csr_rdata[7]) |-> sck_out == cr_rdata[3])
        else $error("sck not at idle level at byte end");
    a_fault_stops_port: assert property ($rose(csr_rdata[4]) |-> ##[0:1] (!cr_rdata[6] && !cr_rdata[4]))
        else $error("fault left enable or master set");
    a_off_no_drive: assert property (!cr_rdata[6] && !$past(cr_rdata[6]) |-> sck_oe_n && mosi_oe_n && miso_oe_n)
        else $error("pin driven while port disabled");
    a_master_drives_sck: assert property (cr_rdata[6] && cr_rdata[4] && $past(cr_rdata[6] && cr_rdata[4])
        |-> !sck_oe_n && !mosi_oe_n)
        else $error("master not driving sck and mosi");
    a_irq_on_flag: assert property ((cr_rdata[7] && flags) [*2] |-> irq)
        else $error("enabled flag without irq");
    a_irq_has_cause: assert property ($rose(irq) |-> ##[0:1] (cr_rdata[7] && flags))
        else $error("irq raised without enabled flag");
    a_overrun_pending: assert property ($rose(csr_rdata[5]) |-> csr_rdata[7])
        else $error("overrun without pending done flag");
    a_overrun_clear: assert property (csr_rd && csr_rdata[5] |-> ##[1:2] !csr_rdata[5])
        else $error("overrun not cleared by status read");
    a_rx_holds: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("rx word changed while stalled");
    a_sck_half_min: assert property ($changed(sck_out) && !sck_oe_n && !$past(sck_oe_n) |=> $stable(sck_out))
        else $error("sck half period below two cycles");
    c_done: cover property ($rose(csr_rdata[7]));
    c_overrun: cover property ($rose(csr_rdata[5]));
    c_fault: cover property ($rose(csr_rdata[4]));
    c_stall: cover property (rx_valid && !rx_ready);
endmodule
bind smp_port smp_port_props i_smp_port_props (
    .sys_clk(sys_clk), .rst(rst), .cr_rdata(cr_rdata), .csr_rd(csr_rd), .csr_rdata(csr_rdata), .irq(irq),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready)
);

// file: sim/tb_smp_port.sv
`timescale 1ns/1ps
module tb_smp_port;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cr_wr = 1'b0, csr_wr = 1'b0, csr_rd = 1'b0, dr_rd = 1'b0, dr_wr = 1'b0;
    logic ss_n_in = 1'b1, rx_ready = 1'b0, sel_n = 1'b1, clk_pol = 1'b0, clk_phase = 1'b0, hold = 1'b0, sck_d = 1'b0;
    logic [7:0] cr_wdata = 8'h00, csr_wdata = 8'h00, dr_wdata = 8'h00, ptx = 8'h00, p1, cfg;
    logic [1:0] md;
    logic [2:0] rt;
    wire logic [7:0] cr_rdata, csr_rdata, dr_rdata, rx_data, prx;
    wire logic irq, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, rx_valid, miso;
    int miscompares = 0, n_compared = 0, cycles = 0, toggles = 0, last_tog = 0, half_seen = 0, tq;
    logic [7:0] rx_q[$];
    localparam logic [2:0] RATES[6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
    localparam int HALFS[6] = '{2, 4, 8, 16, 32, 64};

    always #12.5 sys_clk = ~sys_clk;

    smp_port i_smp_port (
        .sys_clk(sys_clk), .rst(rst), .cr_wr(cr_wr), .cr_wdata(cr_wdata), .cr_rdata(cr_rdata),
        .csr_rd(csr_rd), .csr_wr(csr_wr), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
        .dr_rd(dr_rd), .dr_wr(dr_wr), .dr_wdata(dr_wdata), .dr_rdata(dr_rdata), .irq(irq),
        .ss_n_in(ss_n_in), .sck_in(1'b0), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
        .mosi_in(1'b0), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
        .miso_in(miso), .miso_out(), .miso_oe_n(miso_oe_n),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready)
    );
    smp_slave_model i_smp_slave_model (
        .sys_clk(sys_clk), .sel_n(sel_n), .clk_pol(clk_pol), .clk_phase(clk_phase), .sck(sck_out), .mosi(mosi_out),
        .tx_byte(ptx), .miso(miso), .rx_byte(prx)
    );

    task automatic finish_test;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic strobe(input int k, input logic [7:0] v);
        @(posedge sys_clk);
        case (k)
            0: begin cr_wr <= 1'b1; cr_wdata <= v; end
            1: begin csr_wr <= 1'b1; csr_wdata <= v; end
            2: csr_rd <= 1'b1;
            3: dr_rd <= 1'b1;
            default: begin dr_wr <= 1'b1; dr_wdata <= v; end
        endcase
        @(posedge sys_clk);
        {cr_wr, csr_wr, csr_rd, dr_rd, dr_wr} <= 5'h00;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic xfer(input logic [7:0] b, input bit push, input int mode);
        int t0;
        @(posedge sys_clk);
        ptx <= 8'($urandom);
        sel_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t0 = toggles;
        strobe(4, b);
        if (push) rx_q.push_back(ptx);
        for (int k = 0; k < 3000 && toggles - t0 < 16; k++) begin
            @(posedge sys_clk);
            if (mode == 1 && k == 6) strobe(4, ~b);
            if (mode == 2 && k == 40) begin
                cmp("stalled", 8'h00, 8'(toggles - t0));
                hold <= 1'b0;
            end
        end
        repeat (3) @(posedge sys_clk);
        #1;
        sel_n <= 1'b1;
        cmp("toggles", 8'h10, 8'(toggles - t0));
        cmp("done", 8'h80, csr_rdata & 8'h80);
        cmp("slave_rx", b, prx);
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        sck_d <= sck_out;
        rx_ready <= hold ? 1'b0 : 1'($urandom % 2);
        if (sck_out !== sck_d) begin
            toggles <= toggles + 1;
            half_seen <= cycles - last_tog;
            last_tog <= cycles;
        end
        if (!rst && rx_valid === 1'b1 && rx_ready === 1'b1) cmp("rx_data", rx_q.size() > 0 ? rx_q.pop_front() : 8'hXX, rx_data);
        if (cycles == 40000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(29));
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        cmp("cr_rdata", smp_pkg::CR_RESET, cr_rdata);
        cmp("csr_rdata", smp_pkg::CSR_RESET, csr_rdata);
        cmp("sck_oe_n", 8'h01, {7'h00, sck_oe_n});
        strobe(1, 8'h03);
        for (int i = 0; i < 12; i++) begin
            md = 2'(i % 4);
            rt = RATES[i % 6];
            cfg = {2'h3, rt[2], 1'b1, md, rt[1:0]};
            strobe(0, 8'h00);
            clk_pol <= md[1];
            clk_phase <= md[0];
            hold <= hold | (i == 8);
            strobe(0, cfg);
            cmp("cr_rdata", cfg, cr_rdata);
            xfer(8'($urandom), 1'b1, i == 10 ? 2 : 0);
            cmp("irq", 8'h01, {7'h00, irq});
            cmp("sck_idle", {7'h00, md[1]}, {7'h00, sck_out});
            cmp("half", 8'(HALFS[i % 6]), 8'(half_seen));
            strobe(2, 8'h00);
            strobe(3, 8'h00);
            cmp("dr_rdata", ptx, dr_rdata);
            cmp("csr_rdata", 8'h03, csr_rdata);
        end
        strobe(0, 8'h00);
        clk_pol <= 1'b0;
        clk_phase <= 1'b0;
        strobe(0, 8'hF0);
        xfer(8'hA5, 1'b1, 1);
        cmp("collision", 8'h40, csr_rdata & 8'h40);
        tq = toggles;
        strobe(4, 8'h3C);
        repeat (20) @(posedge sys_clk);
        cmp("ignored", 8'h00, 8'(toggles - tq));
        strobe(2, 8'h00);
        strobe(3, 8'h00);
        cmp("csr_rdata", 8'h03, csr_rdata);
        xfer(8'h5A, 1'b1, 0);
        p1 = ptx;
        strobe(2, 8'h00);
        xfer(8'hC3, 1'b1, 0);
        cmp("overrun", 8'hA0, csr_rdata & 8'hA0);
        strobe(2, 8'h00);
        cmp("overrun_clr", 8'h00, csr_rdata & 8'h20);
        strobe(3, 8'h00);
        cmp("dr_rdata", p1, dr_rdata);
        cmp("csr_rdata", 8'h03, csr_rdata);
        strobe(1, 8'h00);
        @(posedge sys_clk);
        ss_n_in <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        cmp("fault", 8'h10, csr_rdata & 8'h10);
        cmp("cr_off", 8'h00, cr_rdata & 8'h50);
        cmp("sck_oe_n", 8'h01, {7'h00, sck_oe_n});
        @(posedge sys_clk);
        ss_n_in <= 1'b1;
        strobe(0, 8'hF0);
        cmp("refused", 8'h00, cr_rdata & 8'h50);
        strobe(2, 8'h00);
        strobe(0, 8'hF0);
        cmp("cr_rdata", 8'hF0, cr_rdata);
        cmp("fault_clr", 8'h00, csr_rdata & 8'h10);
        finish_test();
    end
endmodule
